// *** common/dmbank_pkg.sv ***
/*
 * Package for the data-memory bank, index and row-pointer register bank.
 * Holds system-register offsets, field positions, reset values, the operand
 * address layout and the state record. Assumes a 7-bit system-register
 * space reached over a plain strobe port in one core clock domain.
 */
// How it works
// R1 - The bank-select location at 79H is four bits wide, and its two upper bits always read zero.
// R2 - Bank-select bits b1 and b0 pick data-memory bank 0 to 3 in plain binary order.
// R3 - Bank select is read and written the same way whichever bank is selected.
// R4 - Software on the small variant must never write the code that picks the fourth bank.
// R5 - The 11-bit index is 7AH bits 2..0, then the nibble at 7BH, then the nibble at 7CH; the code puts 7AH bit 0 at index bit 10, above two zero bits.
// R6 - The index-enable flag is bit 0 of the status-word nibble at 7FH.
// R7 - The 7-bit row pointer is 7AH bits 2..0 followed by the nibble at 7BH; the code puts 7AH bit 0 at pointer bit 6, above two zero bits.
// R8 - The row-pointer enable flag is bit 3 of the nibble at 7AH.
// R9 - Index top bits and row pointer are one storage, so writing one changes the other.
// R10 - Bits 2 and 1 of 7AH are always zero.
// R11 - With the index enable set the index is ORed into bank, row and column of each operand; the code ORs it into plain accesses only.
// R12 - With the row-pointer enable set the pointer replaces bank and row of indirect destinations.
// R13 - All bank, index, pointer and enable bits clear on power-on, clock-stop and chip-enable reset.
// R14 - Constant-zero bits read as zero and ignore what software writes to them.
package dmbank_pkg;

	// System-register offsets
	localparam logic [6:0] DMBANK_OFS_BANK_SELECT = 7'h79;
	localparam logic [6:0] DMBANK_OFS_PTR_HIGH    = 7'h7a;
	localparam logic [6:0] DMBANK_OFS_IDX_MIDDLE  = 7'h7b;
	localparam logic [6:0] DMBANK_OFS_IDX_LOW     = 7'h7c;
	localparam logic [6:0] DMBANK_OFS_STATUS      = 7'h7f;

	// Field positions inside the nibbles
	localparam int DMBANK_POS_ROW_PTR_EN = 3;
	localparam int DMBANK_POS_IDX_TOP    = 0;
	localparam int DMBANK_POS_IDX_EN     = 0;

	// Reset values
	localparam logic [1:0] DMBANK_RST_BANK   = 2'h0;
	localparam logic [3:0] DMBANK_RST_NIBBLE = 4'h0;

	// Widths of the address pieces
	localparam int DMBANK_BANK_W = 4;
	localparam int DMBANK_ROW_W  = 3;
	localparam int DMBANK_COL_W  = 4;
	localparam int DMBANK_IDX_W  = 11;
	localparam int DMBANK_PTR_W  = 7;
	localparam int DMBANK_CNT_W  = 9;

	// Data-memory operand address: bank, row, column
	typedef struct packed {
		logic [3:0] bank;
		logic [2:0] row;
		logic [3:0] col;
	} dmbank_addr_t;

	// Kinds of operand access
	typedef enum logic [1:0] {
		DMBANK_ACC_PLAIN,
		DMBANK_ACC_INDIRECT_DEST,
		DMBANK_ACC_EXEMPT
	} dmbank_acc_t;

	// Operand request from the core
	typedef struct packed {
		logic         valid;
		dmbank_acc_t  kind;
		logic [2:0]   row;
		logic [3:0]   col;
	} dmbank_req_t;

	// Whole state of the block
	typedef struct packed {
		logic [1:0]   bank;
		logic         row_pointer_enable;
		logic         index_top_bit;
		logic [3:0]   index_middle_nibble;
		logic [3:0]   index_lower_nibble;
		logic [3:0]   status_flags_word;
		logic [3:0]   rdata;
		logic         addr_valid;
		dmbank_addr_t addr;
	} dmbank_state_t;

endpackage : dmbank_pkg

// *** design/dmbank_regs.sv ***
/*
 * Bank select, index value and row pointer system registers, with the
 * operand address modification they steer.
 * Assumes strobes synchronous to i_core_clk, never both in one cycle, and
 * reset sources that are already synchronous one-cycle or longer levels.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module dmbank_regs (
	// Clock and resets
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset,
	input  wire logic                   i_clock_stop_reset,
	input  wire logic                   i_chip_enable_reset,
	// Register port
	input  wire logic [6:0]             i_addr,
	input  wire logic [3:0]             i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [3:0]             o_rdata,
	// Index increment
	input  wire logic                   i_index_inc,
	// Operand request and modified address
	input  wire dmbank_pkg::dmbank_req_t i_req,
	output logic                        o_addr_valid,
	output dmbank_pkg::dmbank_addr_t     o_addr,
	// State seen by the core
	output logic      [1:0]             o_bank,
	output logic      [10:0]            o_index_value,
	output logic      [6:0]             o_row_pointer,
	output logic                        o_index_enable_flag,
	output logic                        o_row_pointer_enable,
	output logic      [3:0]             o_status_flags_word
);

	dmbank_pkg::dmbank_state_t s_q;
	dmbank_pkg::dmbank_state_t s_d;

	logic                        any_reset;
	logic [10:0]                 index_value;
	logic [6:0]                  row_pointer;
	logic [8:0]                  inc_sum;
	logic [3:0]                  bank_ext;
	dmbank_pkg::dmbank_addr_t    base;
	dmbank_pkg::dmbank_addr_t    idx_as_addr;

	assign any_reset = i_reset | i_clock_stop_reset | i_chip_enable_reset;

	// R9 shared storage
	// R10 two zero bits
	assign index_value = {s_q.index_top_bit, 2'h0, s_q.index_middle_nibble,
		s_q.index_lower_nibble};
	// R7 row pointer view
	assign row_pointer = {s_q.index_top_bit, 2'h0, s_q.index_middle_nibble};

	// Only the nine live bits count, so 1ffh wraps to zero
	assign inc_sum = {s_q.index_top_bit, s_q.index_middle_nibble,
		s_q.index_lower_nibble} + 9'h001;

	// R2 bank from two bits
	assign bank_ext = {2'h0, s_q.bank};
	assign idx_as_addr = index_value;

	always_comb begin
		s_d = s_q;
		base = '{bank: bank_ext, row: i_req.row, col: i_req.col};

		// Increment first so a same-cycle write takes the location over
		if (i_index_inc) begin
			s_d.index_top_bit = inc_sum[8];
			s_d.index_middle_nibble = inc_sum[7:4];
			s_d.index_lower_nibble = inc_sum[3:0];
		end

		// R3 no bank dependence
		if (i_wr) begin
			case (i_addr)
				// R1 two-bit bank
				// R14 ignore fixed bits
				dmbank_pkg::DMBANK_OFS_BANK_SELECT: begin
					s_d.bank = i_wdata[1:0];
				end
				// R8 enable in bit 3
				// R10 bits 2 and 1 dropped
				dmbank_pkg::DMBANK_OFS_PTR_HIGH: begin
					s_d.row_pointer_enable = i_wdata[dmbank_pkg::DMBANK_POS_ROW_PTR_EN];
					s_d.index_top_bit = i_wdata[dmbank_pkg::DMBANK_POS_IDX_TOP];
				end
				// R5 middle nibble
				dmbank_pkg::DMBANK_OFS_IDX_MIDDLE: begin
					s_d.index_middle_nibble = i_wdata;
				end
				// R5 low nibble
				dmbank_pkg::DMBANK_OFS_IDX_LOW: begin
					s_d.index_lower_nibble = i_wdata;
				end
				// R6 flag in status word
				dmbank_pkg::DMBANK_OFS_STATUS: begin
					s_d.status_flags_word = i_wdata;
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		s_d.rdata = 4'h0;
		if (i_rd) begin
			case (i_addr)
				// R14 zeros read back
				dmbank_pkg::DMBANK_OFS_BANK_SELECT: begin
					s_d.rdata = {2'h0, s_q.bank};
				end
				dmbank_pkg::DMBANK_OFS_PTR_HIGH: begin
					s_d.rdata = {s_q.row_pointer_enable, 2'h0, s_q.index_top_bit};
				end
				dmbank_pkg::DMBANK_OFS_IDX_MIDDLE: begin
					s_d.rdata = s_q.index_middle_nibble;
				end
				dmbank_pkg::DMBANK_OFS_IDX_LOW: begin
					s_d.rdata = s_q.index_lower_nibble;
				end
				dmbank_pkg::DMBANK_OFS_STATUS: begin
					s_d.rdata = s_q.status_flags_word;
				end
				default: begin
					s_d.rdata = 4'h0;
				end
			endcase
		end

		// Address modification uses the register values before this cycle's write
		s_d.addr_valid = i_req.valid;
		s_d.addr = base;
		case (i_req.kind)
			// R11 OR in index
			dmbank_pkg::DMBANK_ACC_PLAIN: begin
				if (s_q.status_flags_word[dmbank_pkg::DMBANK_POS_IDX_EN]) begin
					s_d.addr = base | idx_as_addr;
				end
			end
			// R12 pointer replaces bank and row
			dmbank_pkg::DMBANK_ACC_INDIRECT_DEST: begin
				if (s_q.row_pointer_enable) begin
					s_d.addr = '{bank: row_pointer[6:3], row: row_pointer[2:0],
						col: i_req.col};
				end
			end
			dmbank_pkg::DMBANK_ACC_EXEMPT: begin
				s_d.addr = base;
			end
			default: begin
				s_d.addr = base;
			end
		endcase
		if (!i_req.valid) begin
			s_d.addr = s_q.addr;
		end

		// R13 every reset clears
		if (any_reset) begin
			s_d = '0;
			s_d.bank = dmbank_pkg::DMBANK_RST_BANK;
			s_d.status_flags_word = dmbank_pkg::DMBANK_RST_NIBBLE;
			s_d.index_middle_nibble = dmbank_pkg::DMBANK_RST_NIBBLE;
			s_d.index_lower_nibble = dmbank_pkg::DMBANK_RST_NIBBLE;
		end
	end

	always_ff @(posedge i_core_clk) begin
		s_q <= s_d;
	end

	assign o_rdata = s_q.rdata;
	assign o_addr_valid = s_q.addr_valid;
	assign o_addr = s_q.addr;
	assign o_bank = s_q.bank;
	assign o_index_value = index_value;
	assign o_row_pointer = row_pointer;
	assign o_index_enable_flag = s_q.status_flags_word[dmbank_pkg::DMBANK_POS_IDX_EN];
	assign o_row_pointer_enable = s_q.row_pointer_enable;
	assign o_status_flags_word = s_q.status_flags_word;

endmodule : dmbank_regs

// *** bench/dmbank_chk.sv ***
/* Port assertions for the bank registers. Bound to the design from the bench top. */
`timescale 1ns/1ns
module dmbank_chk (
	// Clock and resets
	input wire logic        i_core_clk,
	input wire logic        i_reset,
	input wire logic        i_clock_stop_reset,
	input wire logic        i_chip_enable_reset,
	// Register port
	input wire logic [6:0]  i_addr,
	input wire logic [3:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [3:0]  o_rdata,
	// State
	input wire logic [1:0]  o_bank,
	input wire logic [10:0] o_index_value,
	input wire logic [6:0]  o_row_pointer,
	input wire logic        o_index_enable_flag,
	input wire logic        o_row_pointer_enable
);
	logic [6:0] wa;
	// Zero when idle, never a mapped offset
	assign wa = i_wr ? i_addr : 7'h0;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset || i_clock_stop_reset || i_chip_enable_reset);
	property p_rb; i_rd && i_addr == 7'h79 |=> o_rdata == {2'h0, o_bank}; endproperty
	a_rb: assert property (p_rb) else $error("bank read");
	property p_wb; wa == 7'h79 |=> o_bank == $past(i_wdata[1:0]); endproperty
	a_wb: assert property (p_wb) else $error("bank write");
	property p_we; wa == 7'h7a |=> o_row_pointer_enable == $past(i_wdata[3]); endproperty
	a_we: assert property (p_we) else $error("pointer enable");
	property p_wz; wa == 7'h7a |=> o_row_pointer[6:4] == {$past(i_wdata[0]), 2'h0}; endproperty
	a_wz: assert property (p_wz) else $error("pointer top");
	property p_wm; wa == 7'h7b |=> o_row_pointer[3:0] == $past(i_wdata); endproperty
	a_wm: assert property (p_wm) else $error("pointer low");
	property p_wl; wa == 7'h7c |=> o_index_value[3:0] == $past(i_wdata); endproperty
	a_wl: assert property (p_wl) else $error("index low");
	property p_wf; wa == 7'h7f |=> o_index_enable_flag == $past(i_wdata[0]); endproperty
	a_wf: assert property (p_wf) else $error("index enable");
	property p_sh; o_index_value[10:4] == o_row_pointer; endproperty
	a_sh: assert property (p_sh) else $error("shared bits");
endmodule : dmbank_chk

// *** bench/dmbank_core.sv ***
/* Core model issuing one-cycle operand requests. Called from the bench. */
`timescale 1ns/1ns
module dmbank_core (
	// Clock
	input wire logic                i_core_clk,
	// Request to the bank
	output dmbank_pkg::dmbank_req_t o_req
);
	initial o_req = '0;
	task automatic issue(dmbank_pkg::dmbank_acc_t k, logic [2:0] r, logic [3:0] c);
		@(posedge i_core_clk);
		o_req <= '{1'b1, k, r, c};
		@(posedge i_core_clk);
		// Idle row and column scrambled, not left stale
		o_req <= '{1'b0, k, ~r, ~c};
		#1;
	endtask : issue
endmodule : dmbank_core

// *** bench/tb_top.sv ***
/* Bench top: register port tasks and scenarios. Needs package, core model, checker. */
`timescale 1ns/1ns
module tb_top;
	logic i_core_clk = 0, i_reset = 1, i_clock_stop_reset = 0, i_chip_enable_reset = 0;
	logic i_wr = 0, i_rd = 0, i_index_inc = 0, o_addr_valid;
	logic o_index_enable_flag, o_row_pointer_enable;
	logic [6:0] i_addr = '0, o_row_pointer;
	logic [3:0] i_wdata = '0, o_rdata, o_status_flags_word;
	logic [1:0] o_bank;
	logic [10:0] o_index_value;
	dmbank_pkg::dmbank_req_t i_req;
	dmbank_pkg::dmbank_addr_t o_addr;
	int bad_count = 0, num_checks = 0, cyc = 0;
	always #50 i_core_clk = ~i_core_clk;
	dmbank_core u_core (.i_core_clk, .o_req(i_req));
	dmbank_regs uut (.i_core_clk, .i_reset, .i_clock_stop_reset, .i_chip_enable_reset,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_index_inc, .i_req, .o_addr_valid,
		.o_addr, .o_bank, .o_index_value, .o_row_pointer, .o_index_enable_flag,
		.o_row_pointer_enable, .o_status_flags_word);
	task automatic chk(string n, logic [10:0] e, logic [10:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wrr(logic [6:0] a, logic [3:0] d);
		@(posedge i_core_clk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 0;
		#1;
	endtask : wrr
	task automatic rdc(string n, logic [6:0] a, logic [3:0] e);
		@(posedge i_core_clk);
		i_rd <= 1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 0;
		#1;
		chk(n, 11'(e), 11'(o_rdata));
	endtask : rdc
	task automatic t_rst;
		for (int k = 0; k < 3; k++) begin
			wrr(7'h7a, 4'h9);
			wrr(7'h79, 4'h2);
			wrr(7'h7b, 4'hf);
			wrr(7'h7c, 4'hf);
			wrr(7'h7f, 4'hf);
			@(posedge i_core_clk);
			i_reset <= (k == 0);
			i_clock_stop_reset <= (k == 1);
			i_chip_enable_reset <= (k == 2);
			@(posedge i_core_clk);
			{i_reset, i_clock_stop_reset, i_chip_enable_reset} <= 3'h0;
			#1;
			chk("reset", 11'h0, 11'({o_bank, o_index_value[10], o_row_pointer_enable}));
			chk("reset idx", 11'h0, o_index_value);
			chk("reset psw", 11'h0, 11'(o_status_flags_word));
		end
		$display("t_rst done");
	endtask : t_rst
	task automatic t_bank;
		for (int b = 0; b < 4; b++) begin
			wrr(7'h79, 4'hc | 4'(b));
			rdc("bank rd", 7'h79, 4'(b));
			chk("bank", 11'(b), 11'(o_bank));
		end
		$display("t_bank done");
	endtask : t_bank
	task automatic t_regs;
		wrr(7'h7a, 4'hf);
		wrr(7'h7b, 4'h5);
		wrr(7'h7c, 4'ha);
		rdc("ptr hi", 7'h7a, 4'h9);
		chk("index", 11'h45a, o_index_value);
		chk("enable", 11'h1, 11'(o_row_pointer_enable));
		wrr(7'h7b, 4'h2);
		chk("shared", 11'h42a, o_index_value);
		chk("rowptr", 11'h42, 11'(o_row_pointer));
		wrr(7'h7f, 4'h1);
		rdc("status", 7'h7f, 4'h1);
		chk("psw", 11'h1, 11'(o_status_flags_word));
		chk("ixe", 11'h1, 11'(o_index_enable_flag));
		rdc("unmapped", 7'h7d, 4'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_mod;
		u_core.issue(dmbank_pkg::DMBANK_ACC_PLAIN, 3'h1, 4'h2);
		chk("valid", 11'h1, 11'(o_addr_valid));
		chk("plain", 11'h192 | 11'h42a, o_addr);
		u_core.issue(dmbank_pkg::DMBANK_ACC_INDIRECT_DEST, 3'h5, 4'h6);
		chk("indirect", {7'h42, 4'h6}, o_addr);
		wrr(7'h7f, 4'h0);
		u_core.issue(dmbank_pkg::DMBANK_ACC_PLAIN, 3'h1, 4'h2);
		chk("unmod", 11'h192, o_addr);
		wrr(7'h7a, 4'h0);
		u_core.issue(dmbank_pkg::DMBANK_ACC_INDIRECT_DEST, 3'h5, 4'h6);
		chk("indir off", 11'h1d6, o_addr);
		wrr(7'h7f, 4'h1);
		u_core.issue(dmbank_pkg::DMBANK_ACC_EXEMPT, 3'h1, 4'h2);
		chk("exempt", 11'h192, o_addr);
		$display("t_mod done");
	endtask : t_mod
	task automatic bump;
		@(posedge i_core_clk);
		i_index_inc <= 1;
		@(posedge i_core_clk);
		i_index_inc <= 0;
		#1;
	endtask : bump
	task automatic t_inc;
		wrr(7'h7a, 4'h1);
		wrr(7'h7b, 4'hf);
		wrr(7'h7c, 4'hf);
		bump();
		chk("inc wrap", 11'h0, o_index_value);
		wrr(7'h7b, 4'h0);
		wrr(7'h7c, 4'hf);
		bump();
		chk("inc carry", 11'h010, o_index_value);
		$display("t_inc done");
	endtask : t_inc
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_reset <= 0;
		t_rst();
		t_bank();
		t_regs();
		t_mod();
		t_inc();
		print_verdict();
	end
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			bad_count++;
			print_verdict();
		end
	end
endmodule : tb_top
bind dmbank_regs dmbank_chk u_chk (.i_core_clk, .i_reset, .i_clock_stop_reset,
	.i_chip_enable_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_bank,
	.o_index_value, .o_row_pointer, .o_index_enable_flag, .o_row_pointer_enable);
